/* design/cpc_channel.sv */
// Compare and PWM channel with a classic Wishbone register slave.
// Function
// R1: Compare mode checks 16-bit compare register against the selected timer pair continuously.
// R2: On match, pin goes high, low, toggles or stays per mode select field.
// R3: Interrupt flag sets in the same cycle the match acts on the pin.
// R4: Writing zero to the whole control register forces the compare latch low.
// R5: No compare while the selected timer counts asynchronously.
// R6: Mode 1010 leaves the pin alone and only raises the interrupt flag.
// R7: Mode 1011 match emits special event trigger and resets the selected timer.
// R8: Special event trigger is not wired to any converter start input.
// R9: PWM mode drives a waveform with up to ten bits of duty resolution.
// R10: PWM period is (period reg plus one) times four clocks times prescale.
// R11: Period timer prescale offers factors 1, 4 or 16.
// R12: After timer equals period: clear timer, set pin unless 0% duty, load duty.
// R13: Postscaler does not alter PWM frequency; it gives a separate slow tick.
// R14: Duty is duty low register as eight MSBs plus control bits 5:4.
// R15: High time equals ten-bit duty times clock period times prescale.
// R16: Duty writes take effect at period end; shadow is read-only in PWM.
// R17: Pin clears when shadow plus latch equals timer extended by two bits.
// R18: Duty beyond the period never clears the pin, so output stays high.
// R19: Software sets period, duty, pin direction, timer, then selects PWM mode.
// R20: Software clears the pin direction bit so results reach the pin.
// R21: Per-channel select bits choose the compare time base; PWM uses period timer.
// R22: A match acts once when equality first arises, not every equal clock.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpc_channel
  import cpc_pkg::*;
#(
  parameter int NUM_TMR = 3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cpc_tmr_s [NUM_TMR-1:0] cmp_tmr,
  output logic [NUM_TMR-1:0] cmp_tmr_clr,
  output logic spec_evt,
  output logic channel_output_pin,
  output logic channel_output_pin_oe,
  output logic channel_irq_flag,
  output logic post_tick
);

  logic ack_r;
  logic [31:0] rdat_r;
  logic [5:0] ctrl_r;
  logic [15:0] cmpv_r;
  logic [1:0] lsb_latch_r;
  logic [7:0] pr_r;
  logic [6:0] tctl_r;
  logic [1:0] tsel_r;
  logic dir_r;
  logic irq_en_r;
  logic irq_flag_r;
  logic pin_r;
  logic [7:0] tmr_r;
  logic [5:0] fc_r;
  logic [3:0] post_r;
  logic post_tick_r;
  logic eq_r;
  logic spev_r;
  logic [NUM_TMR-1:0] tclr_r;

  logic acc;
  logic wr;
  logic lo_en;
  logic hi_en;
  logic [3:0] mode;
  logic is_pwm;
  logic is_cmp;
  logic [5:0] fc_last;
  logic [1:0] ext;
  logic sub_last;
  logic tmr_inc;
  logic pwm_end;
  logic [9:0] duty_buf;
  logic duty_hit;
  logic sel_ok;
  cpc_tmr_s ct;
  logic eq;
  logic cmp_hit;
  logic flag_clr;
  logic ctrl_zero_wr;

  // Bus decode; ack is registered so every access takes one wait state
  assign acc = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = acc && wb_we_i;
  assign lo_en = wr && wb_sel_i[0];
  assign hi_en = wr && wb_sel_i[1];

  assign mode = ctrl_r[3:0];
  assign is_pwm = (mode[3:2] == 2'b11);
  assign is_cmp = (mode == CPC_MODE_TOGGLE) || (mode == CPC_MODE_SET) || (mode == CPC_MODE_CLR) ||
                  (mode == CPC_MODE_SWI) || (mode == CPC_MODE_SPEV);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdat_r <= 32'h0000_0000;
    end else if (acc) begin
      unique case (wb_adr_i)
        CPC_OFF_CTRL: rdat_r <= {26'h0, ctrl_r};
        CPC_OFF_CMPV: rdat_r <= {16'h0, cmpv_r};
        CPC_OFF_DLOW: rdat_r <= {24'h0, cmpv_r[7:0]};
        CPC_OFF_SHAD: rdat_r <= {24'h0, cmpv_r[15:8]};
        CPC_OFF_PER: rdat_r <= {24'h0, pr_r};
        CPC_OFF_TCTL: rdat_r <= {25'h0, tctl_r};
        CPC_OFF_STAT: rdat_r <= {28'h0, dir_r, pin_r, irq_en_r, irq_flag_r};
        CPC_OFF_TSEL: rdat_r <= {30'h0, tsel_r};
        CPC_OFF_TMR: rdat_r <= {24'h0, tmr_r};
        default: rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Control register: mode field and the two duty LSBs
  assign ctrl_zero_wr = lo_en && (wb_adr_i == CPC_OFF_CTRL) && (wb_dat_i[5:0] == 6'h00);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_r <= CPC_CTRL_RST;
    end else if (lo_en && wb_adr_i == CPC_OFF_CTRL) begin
      ctrl_r <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pr_r <= CPC_PER_RST;
      tctl_r <= CPC_TCTL_RST;
      tsel_r <= CPC_TSEL_RST;
      dir_r <= CPC_DIR_RST;
      irq_en_r <= 1'b0;
    end else if (lo_en) begin
      if (wb_adr_i == CPC_OFF_PER) pr_r <= wb_dat_i[7:0];
      if (wb_adr_i == CPC_OFF_TCTL) tctl_r <= wb_dat_i[6:0];
      if (wb_adr_i == CPC_OFF_TSEL) tsel_r <= wb_dat_i[1:0];
      if (wb_adr_i == CPC_OFF_STAT) begin
        irq_en_r <= wb_dat_i[CPC_STAT_IE_POS];
        dir_r <= wb_dat_i[CPC_STAT_DIR_POS];
      end
    end
  end

  // Period timer: four clocks per count times prescale 1, 4 or 16
  always_comb begin
    unique case (tctl_r[1:0])
      2'b00: begin
        fc_last = CPC_FC_LAST_P1;
        ext = fc_r[1:0];
        sub_last = 1'b1;
      end
      2'b01: begin
        fc_last = CPC_FC_LAST_P4;
        ext = fc_r[3:2];
        sub_last = (fc_r[1:0] == 2'h3);
      end
      default: begin
        fc_last = CPC_FC_LAST_P16;
        ext = fc_r[5:4];
        sub_last = (fc_r[3:0] == 4'hF);
      end
    endcase
  end

  assign tmr_inc = tctl_r[CPC_TCTL_ON_POS] && (fc_r == fc_last); // R10 R11
  assign pwm_end = tmr_inc && (tmr_r == pr_r); // R12
  assign duty_buf = {cmpv_r[7:0], ctrl_r[CPC_CTRL_DLSB_POS +: 2]}; // R14
  // Duty beyond the period never meets the extended timer, so the pin stays high
  // The pin is a flop, so the clear is decoded on the last clock before the count reaches the duty value
  assign duty_hit = is_pwm && sub_last &&
                    (({1'b0, tmr_r, ext} + 11'h001) == {1'b0, cmpv_r[15:8], lsb_latch_r}); // R17 R15 R18

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fc_r <= 6'h00;
    end else if (!tctl_r[CPC_TCTL_ON_POS] || fc_r == fc_last) begin
      fc_r <= 6'h00;
    end else begin
      fc_r <= fc_r + 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tmr_r <= 8'h00;
    end else if (pwm_end) begin
      tmr_r <= 8'h00; // R12
    end else if (tmr_inc) begin
      tmr_r <= tmr_r + 8'h01;
    end
  end

  // Postscaler only paces a side tick; the PWM wrap ignores it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      post_r <= 4'h0;
      post_tick_r <= 1'b0;
    end else begin
      post_tick_r <= 1'b0;
      if (pwm_end) begin
        if (post_r == tctl_r[CPC_TCTL_POST_POS +: 4]) begin
          post_r <= 4'h0;
          post_tick_r <= 1'b1; // R13
        end else begin
          post_r <= post_r + 4'h1;
        end
      end
    end
  end

  assign post_tick = post_tick_r;

  // Compare value and duty double buffer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmpv_r <= CPC_CMPV_RST;
    end else begin
      if (lo_en && (wb_adr_i == CPC_OFF_CMPV || wb_adr_i == CPC_OFF_DLOW)) cmpv_r[7:0] <= wb_dat_i[7:0];
      if (hi_en && wb_adr_i == CPC_OFF_CMPV && !is_pwm) cmpv_r[15:8] <= wb_dat_i[15:8]; // R16
      if (lo_en && wb_adr_i == CPC_OFF_SHAD && !is_pwm) cmpv_r[15:8] <= wb_dat_i[7:0]; // R16
      if (is_pwm && pwm_end) cmpv_r[15:8] <= cmpv_r[7:0]; // R12 R16
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lsb_latch_r <= 2'h0;
    end else if (is_pwm && pwm_end) begin
      lsb_latch_r <= ctrl_r[CPC_CTRL_DLSB_POS +: 2]; // R12 R14
    end
  end

  // Compare against the selected time base; async counting disables it
  assign sel_ok = (32'(tsel_r) < NUM_TMR); // R21
  assign ct = sel_ok ? cmp_tmr[tsel_r] : '0;
  assign eq = sel_ok && is_cmp && !ct.async && (ct.count == cmpv_r); // R1 R5
  assign cmp_hit = eq && !eq_r; // R22

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      eq_r <= 1'b0;
    end else begin
      eq_r <= eq;
    end
  end

  // Pin latch: zero control write wins, then PWM, then compare actions
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_r <= 1'b0;
    end else if (ctrl_zero_wr) begin
      pin_r <= 1'b0; // R4
    end else if (is_pwm && pwm_end) begin
      pin_r <= (duty_buf != 10'h000); // R12 R9
    end else if (duty_hit) begin
      pin_r <= 1'b0; // R17
    end else if (cmp_hit) begin
      unique case (mode)
        CPC_MODE_SET: pin_r <= 1'b1; // R2
        CPC_MODE_CLR: pin_r <= 1'b0; // R2
        CPC_MODE_TOGGLE: pin_r <= !pin_r; // R2
        default: pin_r <= pin_r; // R6
      endcase
    end
  end

  // Flag: a hit in the clearing cycle keeps it set
  assign flag_clr = lo_en && (wb_adr_i == CPC_OFF_STAT) && wb_dat_i[CPC_STAT_FLAG_POS];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_flag_r <= 1'b0;
    end else if (cmp_hit) begin
      irq_flag_r <= 1'b1; // R3 R6
    end else if (flag_clr) begin
      irq_flag_r <= 1'b0;
    end
  end

  // Trigger goes only to the timer reset and the trigger port, never to a converter start
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      spev_r <= 1'b0;
      tclr_r <= '0;
    end else begin
      spev_r <= cmp_hit && (mode == CPC_MODE_SPEV); // R7 R8
      tclr_r <= '0;
      if (cmp_hit && mode == CPC_MODE_SPEV) tclr_r[tsel_r] <= 1'b1; // R7
    end
  end

  assign spec_evt = spev_r;
  assign cmp_tmr_clr = tclr_r;
  assign channel_output_pin = pin_r;
  assign channel_output_pin_oe = (is_pwm || is_cmp) && !dir_r;
  assign channel_irq_flag = irq_flag_r && irq_en_r;

  a_hit_sets_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmp_hit |=> irq_flag_r) else $error("match did not set flag"); // R3

  a_set_mode_high: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmp_hit && mode == CPC_MODE_SET && !ctrl_zero_wr && !is_pwm |=> pin_r) else $error("set mode missed"); // R2

  a_toggle_flips_pin: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmp_hit && mode == CPC_MODE_TOGGLE && !ctrl_zero_wr |=> pin_r != $past(pin_r)) else $error("toggle missed"); // R2

  a_swi_pin_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmp_hit && mode == CPC_MODE_SWI && !ctrl_zero_wr |=> $stable(pin_r) && irq_flag_r) else $error("swi touched pin"); // R6

  a_spev_clears_timer: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmp_hit && mode == CPC_MODE_SPEV |=> spec_evt && cmp_tmr_clr[$past(tsel_r)] ##1 !spec_evt)
    else $error("special event wrong"); // R7

  a_async_no_hit: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_ok && ct.async |-> !cmp_hit) else $error("compare during async count"); // R5

  a_hit_once_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmp_hit |=> !cmp_hit) else $error("match acted twice"); // R22

  a_equal_no_action: assert property (@(posedge core_clk) disable iff (!reset_n)
    eq && eq_r && !ctrl_zero_wr && !flag_clr |=> $stable(pin_r) && $stable(irq_flag_r))
    else $error("persisting match acted"); // R22

  a_ctrl_zero_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl_zero_wr |=> !pin_r && mode == CPC_MODE_OFF) else $error("zero control kept pin"); // R4

  a_period_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
    is_pwm && pwm_end && !ctrl_zero_wr && !wr |=> tmr_r == 8'h00 &&
    {cmpv_r[15:8], lsb_latch_r} == $past(duty_buf) && pin_r == ($past(duty_buf) != 10'h000))
    else $error("period end wrong"); // R12

  a_shadow_read_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    is_pwm && !pwm_end && wr |=> $stable(cmpv_r[15:8])) else $error("shadow written in pwm"); // R16

  a_inc_spacing: assert property (@(posedge core_clk) disable iff (!reset_n)
    tmr_inc && tctl_r[1:0] == 2'b00 && $stable(tctl_r) |=> !tmr_inc [*3]) else $error("prescale 1 spacing"); // R10

  c_compare_hit: cover property (@(posedge core_clk) disable iff (!reset_n) cmp_hit && mode == CPC_MODE_TOGGLE);
  c_special_event: cover property (@(posedge core_clk) disable iff (!reset_n) spec_evt);
  c_pwm_wrap_high: cover property (@(posedge core_clk) disable iff (!reset_n) is_pwm && pwm_end && duty_buf != 10'h000);
  c_duty_clear: cover property (@(posedge core_clk) disable iff (!reset_n) duty_hit && pin_r);

endmodule
`default_nettype wire

/* design/cpc_pkg.sv */
// Package for the compare and PWM channel: register map, field layout, reset values, mode codes.
package cpc_pkg;

  // Register byte addresses on the Wishbone slave
  localparam logic [7:0] CPC_OFF_CTRL = 8'h00;
  localparam logic [7:0] CPC_OFF_CMPV = 8'h04;
  localparam logic [7:0] CPC_OFF_DLOW = 8'h08;
  localparam logic [7:0] CPC_OFF_SHAD = 8'h0C;
  localparam logic [7:0] CPC_OFF_PER = 8'h10;
  localparam logic [7:0] CPC_OFF_TCTL = 8'h14;
  localparam logic [7:0] CPC_OFF_STAT = 8'h18;
  localparam logic [7:0] CPC_OFF_TSEL = 8'h1C;
  localparam logic [7:0] CPC_OFF_TMR = 8'h20;

  // Field positions
  localparam int CPC_CTRL_DLSB_POS = 4;
  localparam int CPC_TCTL_ON_POS = 2;
  localparam int CPC_TCTL_POST_POS = 3;
  localparam int CPC_STAT_FLAG_POS = 0;
  localparam int CPC_STAT_IE_POS = 1;
  localparam int CPC_STAT_PIN_POS = 2;
  localparam int CPC_STAT_DIR_POS = 3;

  // Reset values
  localparam logic [5:0] CPC_CTRL_RST = 6'h00;
  localparam logic [15:0] CPC_CMPV_RST = 16'h0000;
  localparam logic [7:0] CPC_PER_RST = 8'hFF;
  localparam logic [6:0] CPC_TCTL_RST = 7'h00;
  localparam logic [1:0] CPC_TSEL_RST = 2'h0;
  localparam logic CPC_DIR_RST = 1'b1;

  // Last fine-count value per prescale choice: 4 clocks times 1, 4 or 16
  localparam logic [5:0] CPC_FC_LAST_P1 = 6'h03;
  localparam logic [5:0] CPC_FC_LAST_P4 = 6'h0F;
  localparam logic [5:0] CPC_FC_LAST_P16 = 6'h3F;

  typedef enum logic [3:0] {
    CPC_MODE_OFF = 4'h0,
    CPC_MODE_TOGGLE = 4'h2,
    CPC_MODE_SET = 4'h8,
    CPC_MODE_CLR = 4'h9,
    CPC_MODE_SWI = 4'hA,
    CPC_MODE_SPEV = 4'hB
  } cpc_mode_e;

  // One 16-bit compare time base as seen by the channel
  typedef struct packed {
    logic [15:0] count;
    logic tick;
    logic async;
  } cpc_tmr_s;

endpackage

/* dv/cpc_tmr_model.sv */
// Model of the compare time bases that feed the channel.
`timescale 1ns/1ps
`default_nettype none
module cpc_tmr_model
  import cpc_pkg::*;
#(
  parameter int NUM_TMR = 3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic async_mode,
  input wire logic [NUM_TMR-1:0] tmr_clr,
  output var cpc_tmr_s [NUM_TMR-1:0] tmr
);
  // A stopped timer sits at zero so every run starts from a known count
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_TMR; i++) begin
      if (!reset_n || !run || tmr_clr[i]) begin
        tmr[i].count <= 16'h0000;
      end else begin
        tmr[i].count <= tmr[i].count + 16'h0001;
      end
      tmr[i].tick <= run;
      tmr[i].async <= async_mode;
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the compare and PWM channel.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpc_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, pin, oe, flag, sev, ptick;
  logic run = 1'b0;
  logic asy = 1'b0;
  cpc_tmr_s [2:0] tmr;
  logic [2:0] tclr;
  int num_errors = 0;
  int num_checks = 0;
  cpc_mode_e md [4] = '{CPC_MODE_SET, CPC_MODE_CLR, CPC_MODE_TOGGLE, CPC_MODE_SWI};
  logic ep [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  always #12.5 core_clk = ~core_clk;
  cpc_channel u_dut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cmp_tmr(tmr),
    .cmp_tmr_clr(tclr), .spec_evt(sev), .channel_output_pin(pin), .channel_output_pin_oe(oe),
    .channel_irq_flag(flag), .post_tick(ptick));
  cpc_tmr_model u_tmr (.core_clk(core_clk), .reset_n(reset_n), .run(run), .async_mode(asy),
    .tmr_clr(tclr), .tmr(tmr));
  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; the request is held until ack is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wait_lv(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s !== v && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      end_sim();
    end
  endtask
  // Steady level over a long window, after the new duty has been loaded
  task automatic hold_lv(input logic v);
    int bad;
    bad = 0;
    repeat (300) @(negedge core_clk);
    repeat (600) begin
      @(negedge core_clk);
      if (pin !== v) bad++;
    end
    chk(bad, 0);
  endtask
  initial begin
    int hi, per, f;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    chk(oe, 1'b0);
    rd(CPC_OFF_PER, 32'hFF);
    rd(CPC_OFF_STAT, 32'h08);
    rd(CPC_OFF_CTRL, 32'h0);
    rd(8'h30, 32'h0);
    rd(CPC_OFF_TMR, 32'h0);
    wr(CPC_OFF_STAT, 32'h3);
    wr(CPC_OFF_CMPV, 32'h0104);
    for (int i = 0; i < 4; i++) begin
      wr(CPC_OFF_CTRL, {28'h0, md[i]});
      run <= 1'b1;
      wait_lv(flag, 1'b1);
      chk(pin, ep[i]);
      chk(oe, 1'b1);
      run <= 1'b0;
      wr(CPC_OFF_STAT, 32'h3);
      rd(CPC_OFF_STAT, {29'h0, ep[i], 2'b10});
    end
    wr(CPC_OFF_CMPV, 32'h0);
    wait_lv(flag, 1'b1);
    wr(CPC_OFF_STAT, 32'h3);
    repeat (10) @(negedge core_clk);
    chk(flag, 1'b0);
    wr(CPC_OFF_CTRL, 32'h0);
    chk(pin, 1'b0);
    asy <= 1'b1;
    wr(CPC_OFF_CMPV, 32'h0020);
    wr(CPC_OFF_CTRL, {28'h0, CPC_MODE_SET});
    run <= 1'b1;
    repeat (300) @(negedge core_clk);
    chk({pin, flag}, 2'b00);
    run <= 1'b0;
    asy <= 1'b0;
    for (int t = 0; t < 2; t++) begin
      wr(CPC_OFF_CTRL, 32'h0);
      wr(CPC_OFF_TSEL, t);
      wr(CPC_OFF_CTRL, {28'h0, CPC_MODE_SPEV});
      run <= 1'b1;
      wait_lv(sev, 1'b1);
      chk(tclr, 3'b001 << t);
      chk(flag, 1'b1);
      @(negedge core_clk);
      chk(sev, 1'b0);
      run <= 1'b0;
      wr(CPC_OFF_STAT, 32'h3);
    end
    wr(CPC_OFF_CTRL, 32'h0);
    wr(CPC_OFF_TSEL, 32'h0);
    for (int p = 0; p < 3; p++) begin
      f = 1 << (2 * p);
      wr(CPC_OFF_PER, 32'h3);
      wr(CPC_OFF_DLOW, 32'h1);
      wr(CPC_OFF_CTRL, 32'h20);
      wr(CPC_OFF_STAT, 32'h2);
      wr(CPC_OFF_TCTL, 32'h0C | p);
      wr(CPC_OFF_CTRL, 32'h2C);
      wait_lv(pin, 1'b0);
      wait_lv(pin, 1'b1);
      wait_lv(pin, 1'b0);
      wait_lv(pin, 1'b1);
      hi = 0;
      do begin
        @(negedge core_clk);
        hi++;
      end while (pin === 1'b1 && hi < 2000);
      per = hi;
      do begin
        @(negedge core_clk);
        per++;
      end while (pin !== 1'b1 && per < 2000);
      chk(hi, 6 * f);
      chk(per, 16 * f);
      wait_lv(ptick, 1'b1);
      per = 0;
      do begin
        @(negedge core_clk);
        per++;
      end while (ptick !== 1'b1 && per < 2000);
      chk(per, 32 * f);
      wr(CPC_OFF_SHAD, 32'h55);
      rd(CPC_OFF_SHAD, 32'h01);
    end
    wr(CPC_OFF_DLOW, 32'hFF);
    wr(CPC_OFF_CTRL, 32'h3C);
    hold_lv(1'b1);
    wr(CPC_OFF_DLOW, 32'h0);
    wr(CPC_OFF_CTRL, 32'h0C);
    hold_lv(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
